// ### core/lpdl_defs.svh
// timing counts, sizes and reset values of the data logger sequencer
// assumes the 100 MHz ref_clk of the sequencer
`ifndef LPDL_DEFS_SVH
`define LPDL_DEFS_SVH
`define LPDL_CLK_PERIOD_NS   64'd10
`define LPDL_MINUTE_NS       64'd60000000000
`define LPDL_MINUTE_CYCLES   (`LPDL_MINUTE_NS / `LPDL_CLK_PERIOD_NS)
`define LPDL_HOUR_MINUTES    6'h3C
`define LPDL_DATA_W          12
`define LPDL_IDX_W           6
`define LPDL_BUF_DEPTH       64
`define LPDL_SUM_W           18
`define LPDL_PROC_WORDS      6
`define LPDL_TX_BYTES        4'hC
`define LPDL_XFER_LAST       2'h3
`define LPDL_BYTE_W          8
`endif

// ### core/lpdl_pkg.sv
// types shared by the data logger sequencer and its output buffer
// assumes lpdl_defs.svh for sizes
`include "lpdl_defs.svh"
package lpdl_pkg;
  typedef logic [`LPDL_DATA_W-1:0] lpdl_sample_type;
  typedef logic [`LPDL_BYTE_W-1:0] lpdl_byte_type;

  typedef struct packed {
    lpdl_sample_type ch1;
    lpdl_sample_type ch0;
  } lpdl_scan_type;

  typedef struct packed {
    lpdl_sample_type avg;
    lpdl_sample_type min;
    lpdl_sample_type max;
  } lpdl_stats_type;

  typedef enum logic [1:0] {
    LPDL_MODE_STANDBY = 2'h0,
    LPDL_MODE_SNOOZE  = 2'h1,
    LPDL_MODE_NORMAL  = 2'h2
  } lpdl_mode_type;

  typedef enum logic [2:0] {
    LPDL_ST_STANDBY = 3'h0,
    LPDL_ST_SCAN    = 3'h1,
    LPDL_ST_XFER    = 3'h3,
    LPDL_ST_PROC    = 3'h2,
    LPDL_ST_ARM     = 3'h6,
    LPDL_ST_SEND    = 3'h7,
    LPDL_ST_WLOW    = 3'h5
  } lpdl_state_type;
endpackage

// ### core/lpdl_buf2.sv
// two-entry buffer with valid/ready on both sides
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module lpdl_buf2
  import lpdl_pkg::*;
(
  input  wire logic            ref_clk,
  input  wire logic            srst,
  input  wire lpdl_pkg::lpdl_byte_type in_data,
  input  wire logic            in_valid,
  output logic                 in_ready,
  output lpdl_pkg::lpdl_byte_type out_data,
  output logic                 out_valid,
  input  wire logic            out_ready
);
  import lpdl_pkg::*;
  lpdl_byte_type slot [2];
  logic          rd_ptr;
  logic          wr_ptr;
  logic [1:0]    fill;
  logic [1:0]    next_fill;
  logic          push;
  logic          pop;

  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign in_ready  = (fill != 2'h2);
  assign next_fill = fill + {1'b0, push} - {1'b0, pop};

  // head word kept in a flop, so the output needs no mux
  always_ff @(posedge ref_clk)
  begin
    if (push && (fill == 2'h0 || (fill == 2'h1 && pop)))
    begin
      out_data <= in_data;
    end
    else if (pop && fill == 2'h2)
    begin
      out_data <= slot[~rd_ptr];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      slot[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      fill   <= 2'h0;
      out_valid <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
      begin
        rd_ptr <= ~rd_ptr;
      end
      fill      <= next_fill;
      out_valid <= (next_fill != 2'h0);
    end
  end
endmodule

// ### core/lpdl_sequencer.sv
// low-power data logger sequencer: minute acquisition, hourly processing,
// wakeup-driven data output
// assumes converter, serial framing and partner pins synchronous to ref_clk
`timescale 1ns/1ps
`include "lpdl_defs.svh"
// Contract
// [R1] minute timer underflow in standby requests snooze
// [R2] each snooze scan converts channels 0 and 1
// [R3] scan starts on timer or snooze trigger
// [R4] channel 0 judged by subtraction unit
// [R5] channel 1 judged by converter lower compare
// [R6] result at or above threshold drives pin high
// [R7] chain: ch0, ch1, threshold, ch0 input
// [R8] judgment events set the two level pins
// [R9] transfer done ends snooze to standby
// [R10] hourly alarm cancels low power into normal
// [R11] compute average, minimum, maximum into processed buffer
// [R12] program next alarm, then re-enter low power
// [R13] wakeup rising edge cancels low power
// [R14] after wakeup, build and send data
// [R15] return to low power only after pin low
// [R16] main module raises pin, reads, then lowers
// [R17] buffer pointer advances per sample, wraps at depth
// [R18] snooze only from standby by designated request
module lpdl_sequencer
  import lpdl_pkg::*;
#(
  parameter logic [35:0] MINUTE_CYCLES = 36'(`LPDL_MINUTE_CYCLES)
)
(
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  input  wire logic                     wakeup_req_pin,
  input  wire logic                     adc_scan_end,
  input  wire lpdl_pkg::lpdl_scan_type  adc_result,
  input  wire lpdl_pkg::lpdl_sample_type ch0_threshold,
  input  wire lpdl_pkg::lpdl_sample_type ch1_threshold,
  input  wire logic [`LPDL_IDX_W-1:0]   meas_depth,
  output logic                          adc_start,
  output lpdl_pkg::lpdl_mode_type       lp_mode,
  output logic                          ch0_level_out_pin,
  output logic                          ch1_level_out_pin,
  output logic                          transfer_done_event,
  output lpdl_pkg::lpdl_byte_type       tx_data,
  output logic                          tx_valid,
  input  wire logic                     tx_ready
);
  import lpdl_pkg::*;

  function automatic lpdl_sample_type avg_of(input logic [`LPDL_SUM_W-1:0] sum,
                                             input logic [`LPDL_IDX_W:0]   cnt);
    logic [`LPDL_SUM_W-1:0] q;
    q = '0;
    if (cnt != '0)
    begin
      q = sum / {{(`LPDL_SUM_W-`LPDL_IDX_W-1){1'b0}}, cnt};
    end
    return q[`LPDL_DATA_W-1:0];
  endfunction

  function automatic lpdl_sample_type pick(input lpdl_sample_type a,
                                           input lpdl_sample_type b,
                                           input logic            take_low);
    if (take_low)
    begin
      return (b < a) ? b : a;
    end
    return (b > a) ? b : a;
  endfunction

  lpdl_state_type           state;
  lpdl_state_type           next_state;
  logic [35:0]              minute_cnt;
  logic                     underflow;
  logic [5:0]               alarm_cnt;
  logic                     alarm_pending;
  logic                     wake_q;
  logic                     wake_pending;
  lpdl_scan_type            scan;
  logic [1:0]               xfer_step;
  lpdl_sample_type          doc_set;
  lpdl_sample_type          doc_in;
  logic                     doc_loaded;
  lpdl_sample_type          meas0 [`LPDL_BUF_DEPTH];
  lpdl_sample_type          meas1 [`LPDL_BUF_DEPTH];
  logic [`LPDL_IDX_W-1:0]   wr_ptr;
  logic [`LPDL_IDX_W:0]     fill_cnt;
  logic [`LPDL_IDX_W-1:0]   rd_idx;
  logic                     proc_done;
  logic [`LPDL_SUM_W-1:0]   sum0;
  logic [`LPDL_SUM_W-1:0]   sum1;
  lpdl_stats_type           acc0;
  lpdl_stats_type           acc1;
  lpdl_sample_type          proc_buf [`LPDL_PROC_WORDS];
  logic [3:0]               tx_idx;
  lpdl_byte_type            tx_byte;
  lpdl_sample_type          tx_word;
  logic                     tx_push;
  logic                     tx_in_ready;
  logic                     wake_rise;
  logic                     chain_end;

  assign underflow = (minute_cnt == '0);
  assign wake_rise = wakeup_req_pin && !wake_q;
  assign chain_end = (state == LPDL_ST_XFER) && (xfer_step == `LPDL_XFER_LAST);
  assign tx_push   = (state == LPDL_ST_SEND) && tx_in_ready;
  assign tx_word   = proc_buf[tx_idx[3:1]];
  assign tx_byte   = tx_idx[0] ? tx_word[7:0] : {4'h0, tx_word[11:8]};

  // periodic wake timer, reloads on underflow
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      minute_cnt <= MINUTE_CYCLES - 36'h1;
    end
    else if (underflow)
    begin
      minute_cnt <= MINUTE_CYCLES - 36'h1;
    end
    else
    begin
      minute_cnt <= minute_cnt - 36'h1;
    end
  end

  // calendar alarm, counted in minutes
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      alarm_cnt     <= `LPDL_HOUR_MINUTES;
      alarm_pending <= 1'b0;
    end
    else
    begin
      if (state == LPDL_ST_ARM)
      begin
        alarm_cnt <= `LPDL_HOUR_MINUTES;                      // [R12]
      end
      else if (underflow && alarm_cnt != 6'h0)
      begin
        alarm_cnt <= alarm_cnt - 6'h1;
      end
      if (underflow && alarm_cnt == 6'h1)
      begin
        alarm_pending <= 1'b1;                                // [R10]
      end
      else if (state == LPDL_ST_PROC && rd_idx == '0 && !proc_done)
      begin
        alarm_pending <= 1'b0;
      end
    end
  end

  // wakeup request edge, set wins over clear
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      wake_q       <= 1'b0;
      wake_pending <= 1'b0;
    end
    else
    begin
      wake_q <= wakeup_req_pin;
      if (wake_rise)
      begin
        wake_pending <= 1'b1;                                 // [R13]
      end
      else if (state == LPDL_ST_SEND && tx_idx == 4'h0 && tx_in_ready)
      begin
        wake_pending <= 1'b0;
      end
    end
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      LPDL_ST_STANDBY:
      begin
        if (alarm_pending)
        begin
          next_state = LPDL_ST_PROC;                          // [R10]
        end
        else if (wake_pending)
        begin
          next_state = LPDL_ST_SEND;                          // [R13] [R14]
        end
        else if (underflow)
        begin
          next_state = LPDL_ST_SCAN;                          // [R1] [R18]
        end
      end
      LPDL_ST_SCAN:
      begin
        if (adc_scan_end)
        begin
          next_state = LPDL_ST_XFER;
        end
      end
      LPDL_ST_XFER:
      begin
        if (chain_end)
        begin
          next_state = LPDL_ST_STANDBY;                       // [R9] [R18]
        end
      end
      LPDL_ST_PROC:
      begin
        if (proc_done)
        begin
          next_state = LPDL_ST_ARM;
        end
      end
      LPDL_ST_ARM:
      begin
        next_state = wake_pending ? LPDL_ST_SEND : LPDL_ST_STANDBY; // [R12]
      end
      LPDL_ST_SEND:
      begin
        if (tx_push && tx_idx == `LPDL_TX_BYTES - 4'h1)
        begin
          next_state = LPDL_ST_WLOW;
        end
      end
      LPDL_ST_WLOW:
      begin
        if (!wakeup_req_pin)
        begin
          next_state = LPDL_ST_STANDBY;                       // [R15]
        end
      end
      default:
      begin
        next_state = LPDL_ST_STANDBY;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state <= LPDL_ST_STANDBY;
    end
    else
    begin
      state <= next_state;
    end
  end

  // mode shown to the outside and scan trigger
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      lp_mode   <= LPDL_MODE_STANDBY;
      adc_start <= 1'b0;
    end
    else
    begin
      adc_start <= (state == LPDL_ST_STANDBY) && (next_state == LPDL_ST_SCAN); // [R3] [R2]
      unique case (next_state)
        LPDL_ST_STANDBY: lp_mode <= LPDL_MODE_STANDBY;
        LPDL_ST_SCAN,
        LPDL_ST_XFER:    lp_mode <= LPDL_MODE_SNOOZE;
        default:         lp_mode <= LPDL_MODE_NORMAL;
      endcase
    end
  end

  // chained transfer: ch0, ch1, threshold, ch0 into judgment input
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      scan                <= '0;
      xfer_step           <= 2'h0;
      doc_set             <= '0;
      doc_in              <= '0;
      doc_loaded          <= 1'b0;
      wr_ptr              <= '0;
      fill_cnt            <= '0;
      transfer_done_event <= 1'b0;
    end
    else
    begin
      doc_loaded          <= 1'b0;
      transfer_done_event <= 1'b0;
      if (state == LPDL_ST_SCAN && adc_scan_end)
      begin
        scan      <= adc_result;                              // [R2]
        xfer_step <= 2'h0;
      end
      if (state == LPDL_ST_XFER)
      begin
        xfer_step <= xfer_step + 2'h1;
        unique case (xfer_step)
          2'h0: meas0[wr_ptr] <= scan.ch0;                    // [R7]
          2'h1: meas1[wr_ptr] <= scan.ch1;                    // [R7]
          2'h2: doc_set <= ch0_threshold;                     // [R7] [R4]
          2'h3:
          begin
            doc_in              <= scan.ch0;                  // [R7] [R4]
            doc_loaded          <= 1'b1;
            transfer_done_event <= 1'b1;                      // [R9]
            if (wr_ptr + 1'b1 >= meas_depth || meas_depth == '0)
            begin
              wr_ptr <= '0;                                   // [R17]
            end
            else
            begin
              wr_ptr <= wr_ptr + 1'b1;                        // [R17]
            end
            if (fill_cnt < {1'b0, meas_depth} || (meas_depth == '0 && fill_cnt == '0))
            begin
              fill_cnt <= fill_cnt + 1'b1;
            end
          end
        endcase
      end
    end
  end

  // level pins, cleared at each new acquisition
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      ch0_level_out_pin <= 1'b0;
      ch1_level_out_pin <= 1'b0;
    end
    else if (adc_start)
    begin
      ch0_level_out_pin <= 1'b0;
      ch1_level_out_pin <= 1'b0;
    end
    else
    begin
      if (doc_loaded && doc_in >= doc_set)
      begin
        ch0_level_out_pin <= 1'b1;                            // [R4] [R6] [R8]
      end
      if (state == LPDL_ST_SCAN && adc_scan_end && adc_result.ch1 >= ch1_threshold)
      begin
        ch1_level_out_pin <= 1'b1;                            // [R5] [R6] [R8]
      end
    end
  end

  // hourly walk over the measurement buffers
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      rd_idx    <= '0;
      proc_done <= 1'b0;
      sum0      <= '0;
      sum1      <= '0;
      acc0      <= '0;
      acc1      <= '0;
    end
    else if (state != LPDL_ST_PROC)
    begin
      rd_idx    <= '0;
      proc_done <= 1'b0;
    end
    else if (!proc_done)
    begin
      if (rd_idx == '0)
      begin
        sum0 <= {{(`LPDL_SUM_W-`LPDL_DATA_W){1'b0}}, meas0[0]};
        sum1 <= {{(`LPDL_SUM_W-`LPDL_DATA_W){1'b0}}, meas1[0]};
        acc0 <= '{avg: '0, min: meas0[0], max: meas0[0]};
        acc1 <= '{avg: '0, min: meas1[0], max: meas1[0]};
      end
      else
      begin
        sum0     <= sum0 + {{(`LPDL_SUM_W-`LPDL_DATA_W){1'b0}}, meas0[rd_idx]}; // [R11]
        sum1     <= sum1 + {{(`LPDL_SUM_W-`LPDL_DATA_W){1'b0}}, meas1[rd_idx]};
        acc0.min <= pick(acc0.min, meas0[rd_idx], 1'b1);
        acc0.max <= pick(acc0.max, meas0[rd_idx], 1'b0);
        acc1.min <= pick(acc1.min, meas1[rd_idx], 1'b1);
        acc1.max <= pick(acc1.max, meas1[rd_idx], 1'b0);
      end
      if ({1'b0, rd_idx} + 1'b1 >= fill_cnt)
      begin
        proc_done <= 1'b1;
      end
      else
      begin
        rd_idx <= rd_idx + 1'b1;
      end
    end
  end

  // processed data buffer: avg, min, max of ch0 then ch1
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < `LPDL_PROC_WORDS; i++)
      begin
        proc_buf[i] <= '0;
      end
    end
    else if (state == LPDL_ST_PROC && proc_done)
    begin
      proc_buf[0] <= (fill_cnt == '0) ? '0 : avg_of(sum0, fill_cnt); // [R11]
      proc_buf[1] <= (fill_cnt == '0) ? '0 : acc0.min;
      proc_buf[2] <= (fill_cnt == '0) ? '0 : acc0.max;
      proc_buf[3] <= (fill_cnt == '0) ? '0 : avg_of(sum1, fill_cnt);
      proc_buf[4] <= (fill_cnt == '0) ? '0 : acc1.min;
      proc_buf[5] <= (fill_cnt == '0) ? '0 : acc1.max;
    end
  end

  // transmit byte index
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      tx_idx <= 4'h0;
    end
    else if (state != LPDL_ST_SEND)
    begin
      tx_idx <= 4'h0;
    end
    else if (tx_push)
    begin
      tx_idx <= tx_idx + 4'h1;                                // [R14]
    end
  end

  lpdl_buf2 u_tx_buf
  (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .in_data   (tx_byte),
    .in_valid  (state == LPDL_ST_SEND),
    .in_ready  (tx_in_ready),
    .out_data  (tx_data),
    .out_valid (tx_valid),
    .out_ready (tx_ready)
  );
endmodule

// ### sim/lpdl_host_model.sv
// main-module model: raises the wakeup pin and takes the serial bytes
// assumes the bench commands the request level and the stall pattern
`timescale 1ns/1ps
module lpdl_host_model
  import lpdl_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    srst,
  input  wire logic                    req,
  input  wire logic                    slow,
  input  wire lpdl_pkg::lpdl_byte_type tx_data,
  input  wire logic                    tx_valid,
  output logic                         tx_ready,
  output logic                         wakeup_req_pin,
  output logic                         rx_stb,
  output lpdl_pkg::lpdl_byte_type      rx_byte
);
  import lpdl_pkg::*;
  logic [2:0] phase;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      phase <= 3'h0;
      tx_ready <= 1'b0;
      wakeup_req_pin <= 1'b0;
    end
    else
    begin
      phase <= phase + 3'h1;
      // slow mode accepts one byte in eight
      tx_ready <= slow ? (phase == 3'h0) : 1'b1;
      wakeup_req_pin <= req;
    end
  end
  assign rx_stb = tx_valid && tx_ready;
  assign rx_byte = tx_data;
endmodule

// ### sim/lpdl_sequencer_properties.sv
// port checker of the data logger sequencer
// assumes it is bound to lpdl_sequencer, one clock ref_clk
`timescale 1ns/1ps
`include "lpdl_defs.svh"
module lpdl_seq_checker
  import lpdl_pkg::*;
#(
  parameter logic [35:0] MINUTE_CYCLES = 36'h14
)
(
  input wire logic                      ref_clk,
  input wire logic                      srst,
  input wire logic                      wakeup_req_pin,
  input wire logic                      adc_scan_end,
  input wire lpdl_pkg::lpdl_scan_type   adc_result,
  input wire lpdl_pkg::lpdl_sample_type ch0_threshold,
  input wire lpdl_pkg::lpdl_sample_type ch1_threshold,
  input wire logic [`LPDL_IDX_W-1:0]    meas_depth,
  input wire logic                      adc_start,
  input wire lpdl_pkg::lpdl_mode_type   lp_mode,
  input wire logic                      ch0_level_out_pin,
  input wire logic                      ch1_level_out_pin,
  input wire logic                      transfer_done_event,
  input wire lpdl_pkg::lpdl_byte_type   tx_data,
  input wire logic                      tx_valid,
  input wire logic                      tx_ready
);
  import lpdl_pkg::*;
  logic [35:0] gap;
  logic        seen;
  logic        ch0_hit;
  logic        ch1_hit;
  logic        sent;
  wire         scan_taken = adc_scan_end && lp_mode == LPDL_MODE_SNOOZE;
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      gap <= 36'h0;
      seen <= 1'b0;
      sent <= 1'b0;
    end
    else
    begin
      gap <= adc_start ? 36'h1 : gap + 36'h1;
      seen <= seen | adc_start;
      sent <= (sent && lp_mode != LPDL_MODE_STANDBY) || (tx_valid && tx_ready);
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (scan_taken)
    begin
      ch0_hit <= adc_result.ch0 >= ch0_threshold;
      ch1_hit <= adc_result.ch1 >= ch1_threshold;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  start_in_snooze_a: assert property (adc_start |-> lp_mode == LPDL_MODE_SNOOZE)
    else $error("scan start outside snooze");
  minute_period_a: assert property (adc_start && seen |-> gap % MINUTE_CYCLES == 36'h0)
    else $error("scan start off the minute grid");
  start_pulse_a: assert property (adc_start |=> !adc_start)
    else $error("scan start longer than one cycle");
  snooze_entry_a: assert property (lp_mode == LPDL_MODE_SNOOZE && $past(lp_mode) != LPDL_MODE_SNOOZE
    |-> adc_start && $past(lp_mode) == LPDL_MODE_STANDBY) else $error("snooze entered wrongly");
  chain_length_a: assert property (scan_taken
    |=> !transfer_done_event [*4] ##1 transfer_done_event) else $error("chain not four steps");
  done_standby_a: assert property (transfer_done_event |-> lp_mode == LPDL_MODE_STANDBY)
    else $error("transfer done without standby");
  pins_clear_a: assert property (adc_start |=> !ch0_level_out_pin && !ch1_level_out_pin)
    else $error("level pins not cleared");
  ch1_judge_a: assert property (scan_taken |=> ch1_level_out_pin == ch1_hit)
    else $error("ch1 level pin wrong");
  ch0_judge_a: assert property (transfer_done_event |=> ch0_level_out_pin == ch0_hit)
    else $error("ch0 level pin wrong");
  wake_exit_a: assert property ($rose(wakeup_req_pin) && lp_mode == LPDL_MODE_STANDBY
    |=> ##1 lp_mode != LPDL_MODE_STANDBY) else $error("wakeup edge ignored");
  tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("byte dropped during stall");
  tx_normal_a: assert property (tx_valid |-> lp_mode == LPDL_MODE_NORMAL)
    else $error("byte offered outside normal");
  wait_low_a: assert property (lp_mode == LPDL_MODE_STANDBY && $past(lp_mode) == LPDL_MODE_NORMAL
    && sent |-> !$past(wakeup_req_pin)) else $error("standby while pin high");
  cover property (scan_taken);
  cover property (tx_valid && !tx_ready);
  cover property (lp_mode == LPDL_MODE_NORMAL && !wakeup_req_pin);
  cover property ($rose(wakeup_req_pin) && lp_mode == LPDL_MODE_SNOOZE);
endmodule
bind lpdl_sequencer lpdl_seq_checker #(.MINUTE_CYCLES(MINUTE_CYCLES)) u_chk (.ref_clk, .srst, .wakeup_req_pin,
  .adc_scan_end, .adc_result, .ch0_threshold, .ch1_threshold, .meas_depth, .adc_start, .lp_mode,
  .ch0_level_out_pin, .ch1_level_out_pin, .transfer_done_event, .tx_data, .tx_valid, .tx_ready);

// ### sim/lpdl_sequencer_bench.sv
// self-checking bench of the data logger sequencer
// assumes lpdl_host_model as the main module and a converter model here
`timescale 1ns/1ps
`include "lpdl_defs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module lpdl_sequencer_bench;
  import lpdl_pkg::*;
  logic                   ref_clk = 1'b0;
  logic                   srst = 1'b1;
  logic                   adc_scan_end = 1'b0;
  lpdl_scan_type          adc_result = '0;
  lpdl_sample_type        ch0_threshold = 12'h200;
  lpdl_sample_type        ch1_threshold = 12'h300;
  logic [`LPDL_IDX_W-1:0] meas_depth = 6'h09;
  logic                   req = 1'b0;
  logic                   slow = 1'b0;
  logic                   adc_start;
  lpdl_mode_type          lp_mode;
  lpdl_mode_type          prev_mode;
  logic                   ch0_level_out_pin;
  logic                   ch1_level_out_pin;
  logic                   transfer_done_event;
  lpdl_byte_type          tx_data;
  logic                   tx_valid;
  logic                   tx_ready;
  logic                   wakeup_req_pin;
  logic                   rx_stb;
  lpdl_byte_type          rx_byte;
  int                     failures = 0;
  int                     n_tests = 0;
  int                     n_proc = 0;
  int                     snap = 0;
  int                     t_proc = 0;
  int                     cyc = 0;
  logic [31:0]            seed = 32'h4B936AC7;
  lpdl_sample_type        s0[$];
  lpdl_sample_type        s1[$];
  lpdl_byte_type          rx_q[$];

  always #5 ref_clk = ~ref_clk;

  lpdl_sequencer #(.MINUTE_CYCLES(36'h14)) u_dut (.ref_clk, .srst, .wakeup_req_pin, .adc_scan_end,
    .adc_result, .ch0_threshold, .ch1_threshold, .meas_depth, .adc_start, .lp_mode, .ch0_level_out_pin,
    .ch1_level_out_pin, .transfer_done_event, .tx_data, .tx_valid, .tx_ready);
  lpdl_host_model u_host (.ref_clk, .srst, .req, .slow, .tx_data, .tx_valid, .tx_ready, .wakeup_req_pin,
    .rx_stb, .rx_byte);

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
    return seed;
  endfunction

  // avg, min or max of one channel over the retained window
  function automatic lpdl_sample_type stat(input int ch, input int kind, input int n);
    int cnt;
    int sum;
    int lo;
    int hi;
    int v;
    cnt = (n < meas_depth) ? n : meas_depth;
    sum = 0;
    lo = 4095;
    hi = 0;
    if (cnt == 0)
      return '0;
    for (int i = n - cnt; i < n; i++)
    begin
      v = ch ? s1[i] : s0[i];
      sum += v;
      lo = (v < lo) ? v : lo;
      hi = (v > hi) ? v : hi;
    end
    return (kind == 0) ? 12'(sum / cnt) : (kind == 1) ? 12'(lo) : 12'(hi);
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic timed_out();
    failures++;
    $display("[ERR] %0t wait ran out", $time);
    wrap_up();
  endtask

  // converter: answers each scan start after 2..5 cycles, results in turn at the thresholds, one below them, then random
  initial
  begin
    forever
    begin
      @(posedge ref_clk);
      if (adc_start === 1'b1)
      begin
        repeat (2 + rnd() % 4) @(posedge ref_clk);
        #1;
        case (s0.size() % 3)
          0: adc_result = {ch1_threshold, ch0_threshold};
          1: adc_result = {ch1_threshold - 12'h001, ch0_threshold - 12'h001};
          default: adc_result = 24'(rnd());
        endcase
        adc_scan_end = 1'b1;
        s0.push_back(adc_result.ch0);
        s1.push_back(adc_result.ch1);
        @(posedge ref_clk);
        #1 adc_scan_end = 1'b0;
      end
    end
  end

  always @(posedge ref_clk)
  begin
    cyc++;
    if (rx_stb === 1'b1)
      rx_q.push_back(rx_byte);
    if (lp_mode === LPDL_MODE_NORMAL && prev_mode !== LPDL_MODE_NORMAL && req === 1'b0)
    begin
      if (n_proc > 0)
        `CHK(cyc - t_proc inside {[1180:1300]}, 1'b1)
      snap = s0.size();
      t_proc = cyc;
      n_proc++;
    end
    prev_mode = lp_mode;
  end

  task automatic wait_proc(input int target);
    int k;
    k = 0;
    while (n_proc < target && k < 1500)
    begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 1500)
      timed_out();
    #1;
  endtask

  task automatic do_wake(input logic stall);
    int k;
    lpdl_sample_type w;
    slow = stall;
    rx_q.delete();
    req = 1'b1;
    k = 0;
    while (rx_q.size() < 12 && k < 3000)
    begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 3000)
      timed_out();
    for (int i = 0; i < 10; i++)
    begin
      @(posedge ref_clk);
      #1;
      `CHK(lp_mode, LPDL_MODE_NORMAL)
    end
    `CHK(rx_q.size(), 12)
    for (int i = 0; i < 6; i++)
    begin
      w = stat(i / 3, i % 3, snap);
      `CHK(rx_q[2 * i], {4'h0, w[11:8]})
      `CHK(rx_q[2 * i + 1], w[7:0])
    end
    req = 1'b0;
    k = 0;
    while (lp_mode === LPDL_MODE_NORMAL && k < 20)
    begin
      @(posedge ref_clk);
      k++;
    end
    #1;
    `CHK(lp_mode !== LPDL_MODE_NORMAL, 1'b1)
  endtask

  initial
  begin
    ch0_threshold = 12'(rnd());
    ch1_threshold = 12'(rnd());
    meas_depth = 6'(rnd() % 63 + 1);
    repeat (5) @(posedge ref_clk);
    #1 srst = 1'b0;
    `CHK(lp_mode, LPDL_MODE_STANDBY)
    wait_proc(1);
    repeat (30 + rnd() % 40) @(posedge ref_clk);
    #1 do_wake(1'b0);
    repeat (rnd() % 50) @(posedge ref_clk);
    #1 do_wake(1'b1);
    // wake raised while the hourly processing runs
    wait_proc(2);
    do_wake(1'b1);
    `CHK(n_proc, 2)
    wrap_up();
  end
endmodule
